// ### src/cip_pkg.sv
package cip_pkg;

    localparam logic [7:0] SFR_PAGE_ONE = 8'h01;
    localparam logic [7:0] SFR_CTRL     = 8'hf8;
    localparam logic [7:0] SFR_STAT     = 8'hc0;
    localparam logic [7:0] SFR_TEST     = 8'hdb;
    localparam logic [7:0] SFR_PTR      = 8'haa;
    localparam logic [7:0] SFR_DLO      = 8'hd8;
    localparam logic [7:0] SFR_DHI      = 8'hd9;

    localparam logic [6:0] IDX_CTRL     = 7'h00;
    localparam logic [6:0] IDX_STAT     = 7'h01;
    localparam logic [6:0] IDX_TEST     = 7'h05;
    localparam logic [6:0] IDX_MVAL2    = 7'h59;

    localparam logic [7:0] IF1_FIRST    = 8'h08;
    localparam logic [7:0] IF1_LAST     = 8'h12;
    localparam logic [7:0] IF2_FIRST    = 8'h20;
    localparam logic [7:0] IF2_LAST     = 8'h2a;

    localparam int         IRQ_BIT      = 4;
    localparam logic [7:0] RST_PTR      = 8'h00;
    localparam logic [7:0] RST_DHI      = 8'h00;
    localparam logic [7:0] RST_DLO      = 8'h01;
    localparam logic [15:0] RST_MVAL    = 16'h0000;
    localparam logic [1:0] BE_NONE      = 2'b00;
    localparam logic [1:0] BE_LOW       = 2'b01;
    localparam logic [1:0] BE_WORD      = 2'b11;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cip_sfr_req_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [1:0]  be;
        logic [6:0]  addr;
        logic [15:0] wdata;
    } cip_ctl_req_t;

    typedef struct packed {
        logic [7:0]   ptr;
        logic [7:0]   hi;
        logic [7:0]   lo;
        logic         pend;
        logic         sel_hi;
        logic         sel_ptr;
        logic [6:0]   idx;
        logic         irq;
        logic [15:0]  mval;
        logic [7:0]   rdata;
        logic         rvalid;
        cip_ctl_req_t ctl;
    } cip_state_t;

endpackage

// ### src/cip_port.sv
`timescale 1ns/1ps
module cip_port (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire cip_pkg::cip_sfr_req_t sfr_req,
    output logic [7:0]                 sfr_rdata,
    output logic                       sfr_rvalid,
    output cip_pkg::cip_ctl_req_t      ctl_req,
    input  wire logic [15:0]           ctl_rdata,
    input  wire logic                  ctl_irq,
    input  wire logic [15:0]           msg_valid_hi
);

    cip_pkg::cip_state_t st;
    cip_pkg::cip_state_t next_st;

    always_comb begin
        logic        on_page;
        logic        dir_hit;
        logic [6:0]  dir_idx;
        logic        in_range;
        logic [15:0] word;
        on_page  = (sfr_req.page == cip_pkg::SFR_PAGE_ONE);
        dir_hit  = on_page && (sfr_req.addr == cip_pkg::SFR_CTRL ||
                   sfr_req.addr == cip_pkg::SFR_STAT || sfr_req.addr == cip_pkg::SFR_TEST);
        dir_idx  = (sfr_req.addr == cip_pkg::SFR_CTRL) ? cip_pkg::IDX_CTRL :
                   (sfr_req.addr == cip_pkg::SFR_STAT) ? cip_pkg::IDX_STAT :
                   cip_pkg::IDX_TEST;
        in_range = (st.ptr >= cip_pkg::IF1_FIRST && st.ptr <= cip_pkg::IF1_LAST) ||
                   (st.ptr >= cip_pkg::IF2_FIRST && st.ptr <= cip_pkg::IF2_LAST);
        word     = (st.idx == cip_pkg::IDX_MVAL2) ? st.mval : ctl_rdata;
        if (st.idx == cip_pkg::IDX_CTRL) begin
            word[cip_pkg::IRQ_BIT] = st.irq;
        end
        next_st        = st;
        next_st.irq    = ctl_irq;
        next_st.mval   = msg_valid_hi;
        next_st.rvalid = 1'b0;
        next_st.pend   = 1'b0;
        next_st.ctl.rd = 1'b0;
        next_st.ctl.wr = 1'b0;
        next_st.ctl.be = cip_pkg::BE_NONE;
        if (st.pend) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = st.sel_ptr ? st.ptr : (st.sel_hi ? word[15:8] : word[7:0]);
        end
        if (sfr_req.wr && on_page && sfr_req.addr == cip_pkg::SFR_PTR) begin
            next_st.ptr = sfr_req.wdata;
        end else if (sfr_req.wr && on_page && sfr_req.addr == cip_pkg::SFR_DHI) begin
            next_st.hi = sfr_req.wdata;
        end else if (sfr_req.wr && on_page && sfr_req.addr == cip_pkg::SFR_DLO) begin
            next_st.lo        = sfr_req.wdata;
            next_st.ctl.wr    = (st.ptr[6:0] != cip_pkg::IDX_MVAL2);
            next_st.ctl.be    = cip_pkg::BE_WORD;
            next_st.ctl.addr  = st.ptr[6:0];
            next_st.ctl.wdata = {st.hi, sfr_req.wdata};
            if (in_range) begin
                next_st.ptr = st.ptr + 8'h01;
            end
        end else if (sfr_req.wr && dir_hit) begin
            next_st.ctl.wr    = 1'b1;
            next_st.ctl.be    = cip_pkg::BE_LOW;
            next_st.ctl.addr  = dir_idx;
            next_st.ctl.wdata = {8'h00, sfr_req.wdata};
        end else if (sfr_req.rd && on_page && (dir_hit || sfr_req.addr == cip_pkg::SFR_PTR ||
                     sfr_req.addr == cip_pkg::SFR_DLO || sfr_req.addr == cip_pkg::SFR_DHI)) begin
            next_st.pend     = 1'b1;
            next_st.sel_ptr  = (sfr_req.addr == cip_pkg::SFR_PTR);
            next_st.sel_hi   = (sfr_req.addr == cip_pkg::SFR_DHI);
            next_st.idx      = dir_hit ? dir_idx : st.ptr[6:0];
            next_st.ctl.rd   = (sfr_req.addr != cip_pkg::SFR_PTR);
            next_st.ctl.addr = next_st.idx;
        end
        if (next_st.ctl.wr && next_st.ctl.addr == cip_pkg::IDX_CTRL) begin
            next_st.ctl.wdata[cip_pkg::IRQ_BIT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st      <= '0;
            st.ptr  <= cip_pkg::RST_PTR;
            st.hi   <= cip_pkg::RST_DHI;
            st.lo   <= cip_pkg::RST_DLO;
            st.mval <= cip_pkg::RST_MVAL;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata  = st.rdata;
    assign sfr_rvalid = st.rvalid;
    assign ctl_req    = st.ctl;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    ptr_incr_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DLO &&
        ((st.ptr >= cip_pkg::IF1_FIRST && st.ptr <= cip_pkg::IF1_LAST) ||
         (st.ptr >= cip_pkg::IF2_FIRST && st.ptr <= cip_pkg::IF2_LAST))
        |=> st.ptr == $past(st.ptr) + 8'h01)
        else $error("pointer did not advance in interface range");

    ptr_hold_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DLO &&
        (st.ptr < cip_pkg::IF1_FIRST || st.ptr > cip_pkg::IF2_LAST ||
         (st.ptr > cip_pkg::IF1_LAST && st.ptr < cip_pkg::IF2_FIRST))
        |=> $stable(st.ptr))
        else $error("pointer moved outside interface range");

    ptr_write_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_PTR
        |=> st.ptr == $past(sfr_req.wdata))
        else $error("pointer write did not land");

    ptr_read_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_PTR
        |=> !ctl_req.rd ##1 sfr_rvalid && sfr_rdata == $past(st.ptr, 2))
        else $error("pointer read returned wrong value");

    word_commit_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DLO &&
        st.ptr[6:0] != cip_pkg::IDX_CTRL && st.ptr[6:0] != cip_pkg::IDX_MVAL2
        |=> ctl_req.wr && ctl_req.be == cip_pkg::BE_WORD &&
            ctl_req.addr == $past(st.ptr[6:0]) &&
            ctl_req.wdata == {$past(st.hi), $past(sfr_req.wdata)})
        else $error("low byte write did not commit the word");

    hi_hold_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DHI |=> !ctl_req.wr)
        else $error("high byte write reached the controller");

    mval_ro_a: assert property (
        ctl_req.wr |-> ctl_req.addr != cip_pkg::IDX_MVAL2)
        else $error("write reached read-only valid flags");

    mval_read_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DLO && st.ptr[6:0] == cip_pkg::IDX_MVAL2
        |-> ##2 sfr_rvalid && sfr_rdata == $past(msg_valid_hi[7:0], 2))
        else $error("valid flag read returned wrong byte");

    mval_high_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DHI && st.ptr[6:0] == cip_pkg::IDX_MVAL2
        |-> ##2 sfr_rvalid && sfr_rdata == $past(msg_valid_hi[15:8], 2))
        else $error("valid flag high read returned wrong byte");

    irq_flag_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_CTRL
        |-> ##2 sfr_rvalid && sfr_rdata[cip_pkg::IRQ_BIT] == $past(ctl_irq, 2))
        else $error("summary flag does not follow controller");

    irq_window_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DLO && st.ptr[6:0] == cip_pkg::IDX_CTRL
        |-> ##2 sfr_rvalid && sfr_rdata[cip_pkg::IRQ_BIT] == $past(ctl_irq, 2))
        else $error("summary flag wrong through the window");

    irq_wr_ignored_a: assert property (
        ctl_req.wr && ctl_req.addr == cip_pkg::IDX_CTRL |-> !ctl_req.wdata[cip_pkg::IRQ_BIT])
        else $error("summary bit passed to controller on write");

    direct_path_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_STAT
        |=> ctl_req.wr && ctl_req.addr == cip_pkg::IDX_STAT &&
            ctl_req.be == cip_pkg::BE_LOW && ctl_req.wdata[7:0] == $past(sfr_req.wdata))
        else $error("direct status write missed the shared word");

    direct_ctrl_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_CTRL
        |=> ctl_req.wr && ctl_req.addr == cip_pkg::IDX_CTRL &&
            ctl_req.be == cip_pkg::BE_LOW)
        else $error("direct control write missed the shared word");

    direct_test_a: assert property (
        sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_TEST
        |=> ctl_req.wr && ctl_req.addr == cip_pkg::IDX_TEST &&
            ctl_req.be == cip_pkg::BE_LOW && ctl_req.wdata[7:0] == $past(sfr_req.wdata))
        else $error("direct test write missed the shared word");

    win_low_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DLO &&
        st.ptr[6:0] != cip_pkg::IDX_CTRL && st.ptr[6:0] != cip_pkg::IDX_MVAL2
        |=> ctl_req.rd ##1 sfr_rvalid && sfr_rdata == $past(ctl_rdata[7:0]))
        else $error("low window read missed the controller word");

    win_high_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DHI && st.ptr[6:0] != cip_pkg::IDX_MVAL2
        |=> ctl_req.rd ##1 sfr_rvalid && sfr_rdata == $past(ctl_rdata[15:8]))
        else $error("high window read missed the controller word");

    read_timing_a: assert property (
        sfr_req.rd && !sfr_req.wr && sfr_req.page == cip_pkg::SFR_PAGE_ONE &&
        sfr_req.addr == cip_pkg::SFR_DHI
        |=> ctl_req.rd && ctl_req.addr == $past(st.ptr[6:0]) ##1 sfr_rvalid)
        else $error("window read not answered in two cycles");

    other_page_a: assert property (
        (sfr_req.rd || sfr_req.wr) && sfr_req.page != cip_pkg::SFR_PAGE_ONE
        |=> !ctl_req.rd && !ctl_req.wr && $stable(st.ptr))
        else $error("access on another page was not ignored");

    answer_src_a: assert property (
        sfr_rvalid |-> $past(sfr_req.rd, 2))
        else $error("read answer without a read request");

endmodule // cip_port

// ### sim/cip_ctl_model.sv
`timescale 1ns/1ps
module cip_ctl_model (
    input  wire logic                  ref_clk,
    input  wire cip_pkg::cip_ctl_req_t ctl_req,
    output logic [15:0]                ctl_rdata
);
    logic [15:0] mem [128];

    initial foreach (mem[i]) mem[i] = 16'h0000;
    assign ctl_rdata = mem[ctl_req.addr];
    // Byte enables decide whether the high byte is touched.
    always @(posedge ref_clk) begin
        if (ctl_req.wr) begin
            mem[ctl_req.addr][7:0] <= ctl_req.wdata[7:0];
            if (ctl_req.be[1]) begin
                mem[ctl_req.addr][15:8] <= ctl_req.wdata[15:8];
            end
        end
    end
endmodule // cip_ctl_model

// ### sim/can_indirect_register_port_tb_top.sv
`timescale 1ns/1ps
module can_indirect_register_port_tb_top;
    logic                  ref_clk = 1'b0;
    logic                  reset = 1'b1;
    cip_pkg::cip_sfr_req_t sfr_req = '0;
    logic [7:0]            sfr_rdata;
    logic                  sfr_rvalid;
    cip_pkg::cip_ctl_req_t ctl_req;
    logic [15:0]           ctl_rdata;
    logic                  ctl_irq = 1'b0;
    logic [15:0]           msg_valid_hi = 16'h0000;
    int                    fail_count = 0;
    int                    checks = 0;
    logic [15:0]           w;
    logic [7:0]            tab [8] = '{8'h07, 8'h08, 8'h12, 8'h13, 8'h1f, 8'h20, 8'h2a, 8'h2b};

    cip_port dut_u (.ref_clk(ref_clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .sfr_rvalid(sfr_rvalid), .ctl_req(ctl_req), .ctl_rdata(ctl_rdata), .ctl_irq(ctl_irq),
        .msg_valid_hi(msg_valid_hi));
    cip_ctl_model ctl_u (.ref_clk(ref_clk), .ctl_req(ctl_req), .ctl_rdata(ctl_rdata));

    task automatic close_out;
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [8:0] got, input logic [8:0] e);
        checks++;
        if (got !== e) begin
            fail_count++;
            $display("Error %0t: read got %h expected %h", $time, got, e);
        end
    endtask

    task automatic req(input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_req <= {r, ~r, cip_pkg::SFR_PAGE_ONE, a, d};
        @(posedge ref_clk);
        sfr_req <= '0;
    endtask

    // A missing answer is expected when the top bit of e is clear.
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        req(1'b1, a, 8'h00);
        @(posedge ref_clk);
        #1;
        cmp(e[8] ? {sfr_rvalid, sfr_rdata} : {sfr_rvalid, 8'h00}, e);
        @(posedge ref_clk);
    endtask

    function automatic logic [7:0] incr(input logic [7:0] p);
        if ((p >= cip_pkg::IF1_FIRST && p <= cip_pkg::IF1_LAST) ||
            (p >= cip_pkg::IF2_FIRST && p <= cip_pkg::IF2_LAST)) begin
            return p + 8'h01;
        end
        return p;
    endfunction

    initial forever #25 ref_clk = ~ref_clk;

    initial begin
        #200000;
        fail_count++;
        close_out;
    end

    initial begin
        void'($urandom(32'he966));
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        rd(cip_pkg::SFR_PTR, {1'b1, cip_pkg::RST_PTR});
        rd(8'h00, 9'h000);
        @(posedge ref_clk);
        sfr_req <= {2'b01, 8'h00, cip_pkg::SFR_PTR, 8'h77};
        @(posedge ref_clk);
        sfr_req <= '0;
        rd(cip_pkg::SFR_PTR, {1'b1, cip_pkg::RST_PTR});
        msg_valid_hi <= 16'($urandom);
        req(1'b0, cip_pkg::SFR_PTR, 8'h59);
        req(1'b0, cip_pkg::SFR_DHI, 8'hff);
        req(1'b0, cip_pkg::SFR_DLO, 8'hff);
        rd(cip_pkg::SFR_DLO, {1'b1, msg_valid_hi[7:0]});
        rd(cip_pkg::SFR_DHI, {1'b1, msg_valid_hi[15:8]});
        for (int i = 0; i < 8; i++) begin
            w = 16'($urandom);
            req(1'b0, cip_pkg::SFR_PTR, 8'h30 + 8'($urandom_range(15)));
            req(1'b0, cip_pkg::SFR_DHI, w[15:8]);
            req(1'b0, cip_pkg::SFR_DLO, w[7:0]);
            rd(cip_pkg::SFR_DLO, {1'b1, w[7:0]});
            rd(cip_pkg::SFR_DHI, {1'b1, w[15:8]});
        end
        foreach (tab[i]) begin
            req(1'b0, cip_pkg::SFR_PTR, tab[i]);
            req(1'b0, cip_pkg::SFR_DLO, 8'h3c);
            rd(cip_pkg::SFR_PTR, {1'b1, incr(tab[i])});
        end
        for (int k = 0; k < 2; k++) begin
            ctl_irq <= ~k[0];
            req(1'b0, cip_pkg::SFR_CTRL, 8'hff);
            req(1'b0, cip_pkg::SFR_PTR, 8'h00);
            rd(cip_pkg::SFR_DLO, {1'b1, 3'b111, ~k[0], 4'hf});
            rd(cip_pkg::SFR_CTRL, {1'b1, 3'b111, ~k[0], 4'hf});
        end
        req(1'b0, cip_pkg::SFR_STAT, 8'h5a);
        req(1'b0, cip_pkg::SFR_PTR, {1'b0, cip_pkg::IDX_STAT});
        rd(cip_pkg::SFR_DLO, 9'h15a);
        req(1'b0, cip_pkg::SFR_PTR, {1'b0, cip_pkg::IDX_TEST});
        req(1'b0, cip_pkg::SFR_DLO, 8'ha5);
        rd(cip_pkg::SFR_TEST, 9'h1a5);
        req(1'b0, cip_pkg::SFR_TEST, 8'h3c);
        rd(cip_pkg::SFR_DLO, 9'h13c);
        close_out;
    end
endmodule // can_indirect_register_port_tb_top
